/* File: inc/gpef_pkg.sv */
package gpef_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned GPEF_IDX_PORT_E_DATA = 8;
  localparam int unsigned GPEF_IDX_PORT_F_DATA = 9;
  localparam int unsigned GPEF_IDX_PORT_E_DIR = 10;
  localparam int unsigned GPEF_IDX_PORT_F_DIR = 11;
  localparam logic [11:0] GPEF_ADDR_PORT_E_DATA = 12'(GPEF_IDX_PORT_E_DATA * 4);
  localparam logic [11:0] GPEF_ADDR_PORT_F_DATA = 12'(GPEF_IDX_PORT_F_DATA * 4);
  localparam logic [11:0] GPEF_ADDR_PORT_E_DIR = 12'(GPEF_IDX_PORT_E_DIR * 4);
  localparam logic [11:0] GPEF_ADDR_PORT_F_DIR = 12'(GPEF_IDX_PORT_F_DIR * 4);

  // ----------------------------------------------------------------------
  // Widths, field positions, reset values
  // ----------------------------------------------------------------------
  localparam int unsigned GPEF_E_WIDTH = 8;
  localparam int unsigned GPEF_F_WIDTH = 4;
  localparam int unsigned GPEF_E_SCK = 7;
  localparam int unsigned GPEF_E_MOSI = 6;
  localparam int unsigned GPEF_E_MISO = 5;
  localparam int unsigned GPEF_E_SEL = 4;
  localparam int unsigned GPEF_E_TCH1 = 3;
  localparam int unsigned GPEF_E_TCH0 = 2;
  localparam int unsigned GPEF_E_RXD = 1;
  localparam int unsigned GPEF_E_TXD = 0;
  localparam logic [7:0] GPEF_E_DIR_RESET = 8'h00;
  localparam logic [3:0] GPEF_F_DIR_RESET = 4'h0;
  localparam logic [1:0] GPEF_ELS_GPIO = 2'h0;

  // ----------------------------------------------------------------------
  // Peripheral ownership and drive signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic spi_enable_bit;
    logic spi_master_select;
    logic mode_fault_enable;
    logic sck_out;
    logic mosi_out;
    logic miso_out;
    logic serial_iface_enable;
    logic txd_out;
    logic [11:0] edge_level_select;
    logic [5:0] tch_oe;
    logic [5:0] tch_out;
  } gpef_periph_t;

  typedef struct packed {
    logic [7:0] e_pin_sync;
    logic [3:0] f_pin_sync;
  } gpef_pins_t;

endpackage

/* File: src/gpef_ports.sv */
`timescale 1ns/1ps
module gpef_ports
  import gpef_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic spi_enable_bit_i,
  input wire logic spi_master_select_i,
  input wire logic mode_fault_enable_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_mosi_out_i,
  input wire logic spi_miso_out_i,
  input wire logic serial_iface_enable_i,
  input wire logic serial_txd_out_i,
  input wire logic [11:0] edge_level_select_i,
  input wire logic [5:0] timer_ch_oe_i,
  input wire logic [5:0] timer_ch_out_i,
  input wire logic [7:0] port_e_pin_i,
  input wire logic [3:0] port_f_pin_i,
  output logic [7:0] port_e_pin_o,
  output logic [7:0] port_e_pin_oe_o,
  output logic [3:0] port_f_pin_o,
  output logic [3:0] port_f_pin_oe_o,
  output logic [7:0] port_e_in_o,
  output logic [3:0] port_f_in_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] port_e_data_latch;
    logic [3:0] port_f_data_latch;
    logic [7:0] port_e_direction;
    logic [3:0] port_f_direction;
    gpef_pins_t sync1;
    gpef_pins_t sync2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] e_out;
    logic [7:0] e_oe;
    logic [3:0] f_out;
    logic [3:0] f_oe;
  } gpef_state_t;

  gpef_state_t state;
  gpef_state_t next_state;
  gpef_periph_t per;

  assign per.spi_enable_bit = spi_enable_bit_i;
  assign per.spi_master_select = spi_master_select_i;
  assign per.mode_fault_enable = mode_fault_enable_i;
  assign per.sck_out = spi_sck_out_i;
  assign per.mosi_out = spi_mosi_out_i;
  assign per.miso_out = spi_miso_out_i;
  assign per.serial_iface_enable = serial_iface_enable_i;
  assign per.txd_out = serial_txd_out_i;
  assign per.edge_level_select = edge_level_select_i;
  assign per.tch_oe = timer_ch_oe_i;
  assign per.tch_out = timer_ch_out_i;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic timer_owns(input logic [11:0] els, input int unsigned ch);
    return els[ch*2 +: 2] != GPEF_ELS_GPIO;
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pin);
    return (dir & latch) | (~dir & pin);
  endfunction

  // ----------------------------------------------------------------------
  // SPI pin claims (bits 3..0 map to E7..E4)
  // ----------------------------------------------------------------------
  logic spi_slave;
  logic spi_sel_own;
  logic [3:0] spi_own;
  logic [3:0] spi_oe;
  logic [3:0] spi_out;

  always_comb begin
    spi_slave = per.spi_enable_bit && !per.spi_master_select;
    // Select goes back to the port for a master without fault check
    spi_sel_own = per.spi_enable_bit &&
                  !(per.spi_master_select && !per.mode_fault_enable);
    spi_own[3] = per.spi_enable_bit;
    spi_own[2] = per.spi_enable_bit;
    spi_own[1] = per.spi_enable_bit;
    spi_own[0] = spi_sel_own;
    spi_oe[3] = per.spi_master_select;
    spi_oe[2] = per.spi_master_select;
    spi_oe[1] = !per.spi_master_select;
    // Select is input-only while owned
    spi_oe[0] = 1'b0;
    spi_out[3] = per.sck_out;
    spi_out[2] = per.mosi_out;
    spi_out[1] = per.miso_out;
    spi_out[0] = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Timer pin claims (channel n)
  // ----------------------------------------------------------------------
  logic [5:0] tim_own;

  always_comb begin
    for (int c = 0; c < 6; c++) begin
      tim_own[c] = timer_owns(per.edge_level_select, c);
    end
  end

  // ----------------------------------------------------------------------
  // Serial pin claims (bit 1 is E1, bit 0 is E0)
  // ----------------------------------------------------------------------
  logic [1:0] sci_own;
  logic [1:0] sci_oe;
  logic [1:0] sci_out;

  always_comb begin
    sci_own[1] = per.serial_iface_enable;
    sci_own[0] = per.serial_iface_enable;
    // Receive line is sensed only
    sci_oe[1] = 1'b0;
    sci_oe[0] = 1'b1;
    sci_out[1] = 1'b0;
    sci_out[0] = per.txd_out;
  end

  // ----------------------------------------------------------------------
  // Per-pin ownership map
  // ----------------------------------------------------------------------
  logic [7:0] e_own;
  logic [7:0] e_per_oe;
  logic [7:0] e_per_out;
  logic [3:0] f_own;
  logic [3:0] f_per_oe;
  logic [3:0] f_per_out;

  always_comb begin
    e_own = {spi_own, tim_own[1:0], sci_own};
    e_per_oe = {spi_oe, per.tch_oe[1:0], sci_oe};
    e_per_out = {spi_out, per.tch_out[1:0], sci_out};
    f_own = tim_own[5:2];
    f_per_oe = per.tch_oe[5:2];
    f_per_out = per.tch_out[5:2];
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic setup;
  logic wr;
  logic hit_e_data;
  logic hit_f_data;
  logic hit_e_dir;
  logic hit_f_dir;
  logic hit;

  always_comb begin
    setup = psel_i && !penable_i;
    wr = setup && pwrite_i && pstrb_i[0];
    hit_e_data = paddr_i == GPEF_ADDR_PORT_E_DATA;
    hit_f_data = paddr_i == GPEF_ADDR_PORT_F_DATA;
    hit_e_dir = paddr_i == GPEF_ADDR_PORT_E_DIR;
    hit_f_dir = paddr_i == GPEF_ADDR_PORT_F_DIR;
    hit = hit_e_data || hit_f_data || hit_e_dir || hit_f_dir;
  end

  // ----------------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------------
  logic wr_e_data;
  logic wr_f_data;
  logic wr_e_dir;
  logic wr_f_dir;

  always_comb begin
    wr_e_data = wr && hit_e_data;
    wr_f_data = wr && hit_f_data;
    wr_e_dir = wr && hit_e_dir;
    wr_f_dir = wr && hit_f_dir;
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0] rd_e_data;
  logic [3:0] rd_f_data;
  logic [31:0] rd_word;

  always_comb begin
    rd_e_data = read_mux(state.port_e_direction, state.port_e_data_latch,
                         state.sync2.e_pin_sync);
    rd_f_data = 4'(read_mux({4'h0, state.port_f_direction},
                            {4'h0, state.port_f_data_latch},
                            {4'h0, state.sync2.f_pin_sync}));
    // Unused upper bits and unmapped reads give zero
    rd_word = 32'h0000_0000;
    if (hit_e_data) begin
      rd_word[7:0] = rd_e_data;
    end
    if (hit_f_data) begin
      rd_word[3:0] = rd_f_data;
    end
    if (hit_e_dir) begin
      rd_word[7:0] = state.port_e_direction;
    end
    if (hit_f_dir) begin
      rd_word[3:0] = state.port_f_direction;
    end
  end

  // ----------------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------------
  logic [7:0] gpio_e_oe;
  logic [7:0] gpio_e_out;
  logic [3:0] gpio_f_oe;
  logic [3:0] gpio_f_out;
  logic [7:0] pad_e_oe;
  logic [7:0] pad_e_out;
  logic [3:0] pad_f_oe;
  logic [3:0] pad_f_out;

  always_comb begin
    // Follow a write at the same edge as the registers do
    gpio_e_oe = wr_e_dir ? pwdata_i[7:0] : state.port_e_direction;
    gpio_e_out = wr_e_data ? pwdata_i[7:0] : state.port_e_data_latch;
    gpio_f_oe = wr_f_dir ? pwdata_i[3:0] : state.port_f_direction;
    gpio_f_out = wr_f_data ? pwdata_i[3:0] : state.port_f_data_latch;
    for (int i = 0; i < 8; i++) begin
      if (e_own[i]) begin
        pad_e_oe[i] = e_per_oe[i];
        pad_e_out[i] = e_per_out[i];
      end else begin
        pad_e_oe[i] = gpio_e_oe[i];
        pad_e_out[i] = gpio_e_out[i];
      end
    end
    if (spi_slave) begin
      pad_e_oe[GPEF_E_SEL] = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      if (f_own[i]) begin
        pad_f_oe[i] = f_per_oe[i];
        pad_f_out[i] = f_per_out[i];
      end else begin
        pad_f_oe[i] = gpio_f_oe[i];
        pad_f_out[i] = gpio_f_out[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.sync1.e_pin_sync = port_e_pin_i;
    next_state.sync1.f_pin_sync = port_f_pin_i;
    next_state.sync2 = state.sync1;
    // Answer in the access cycle after setup
    next_state.pready = setup;
    next_state.pslverr = setup && !hit;
    if (setup && !pwrite_i) begin
      next_state.prdata = rd_word;
    end
    if (wr_e_data) begin
      next_state.port_e_data_latch = pwdata_i[7:0];
    end
    if (wr_f_data) begin
      next_state.port_f_data_latch = pwdata_i[3:0];
    end
    if (wr_e_dir) begin
      next_state.port_e_direction = pwdata_i[7:0];
    end
    if (wr_f_dir) begin
      next_state.port_f_direction = pwdata_i[3:0];
    end
    // Registered pad drive
    next_state.e_oe = pad_e_oe;
    next_state.e_out = pad_e_out;
    next_state.f_oe = pad_f_oe;
    next_state.f_out = pad_f_out;
    // Data latches keep contents through reset
    if (!reset_n_i) begin
      next_state.port_e_direction = GPEF_E_DIR_RESET;
      next_state.port_f_direction = GPEF_F_DIR_RESET;
      next_state.e_oe = 8'h00;
      next_state.f_oe = 4'h0;
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;
      next_state.prdata = 32'h0000_0000;
      next_state.e_out = 8'h00;
      next_state.f_out = 4'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_o = state.prdata;
  assign pready_o = state.pready;
  assign pslverr_o = state.pslverr;
  assign port_e_pin_o = state.e_out;
  assign port_e_pin_oe_o = state.e_oe;
  assign port_f_pin_o = state.f_out;
  assign port_f_pin_oe_o = state.f_oe;
  assign port_e_in_o = state.sync2.e_pin_sync;
  assign port_f_in_o = state.sync2.f_pin_sync;

endmodule

/* File: test/gpef_pins_model.sv */
`timescale 1ns/1ps
module gpef_pins_model (
  input wire logic [7:0] e_out_i,
  input wire logic [7:0] e_oe_i,
  input wire logic [3:0] f_out_i,
  input wire logic [3:0] f_oe_i,
  input wire logic [11:0] ext_i,
  output logic [7:0] e_lvl_o,
  output logic [3:0] f_lvl_o
);
  // Pad wins where the port drives, else the outside circuit
  assign e_lvl_o = (e_oe_i & e_out_i) | (~e_oe_i & ext_i[7:0]);
  assign f_lvl_o = (f_oe_i & f_out_i) | (~f_oe_i & ext_i[11:8]);
endmodule

/* File: test/gpef_ports_asserts.sv */
`timescale 1ns/1ps
module gpef_ports_asserts
  import gpef_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic spi_enable_bit_i,
  input wire logic spi_master_select_i,
  input wire logic mode_fault_enable_i,
  input wire logic spi_miso_out_i,
  input wire logic serial_iface_enable_i,
  input wire logic serial_txd_out_i,
  input wire logic [11:0] edge_level_select_i,
  input wire logic [5:0] timer_ch_oe_i,
  input wire logic [5:0] timer_ch_out_i,
  input wire logic [7:0] port_e_pin_o,
  input wire logic [7:0] port_e_pin_oe_o,
  input wire logic [3:0] port_f_pin_oe_o
);
  logic set_up;
  logic mapped;
  assign set_up = psel_i && !penable_i;
  assign mapped = paddr_i inside {GPEF_ADDR_PORT_E_DATA, GPEF_ADDR_PORT_F_DATA,
    GPEF_ADDR_PORT_E_DIR, GPEF_ADDR_PORT_F_DIR};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  AST_READY_PULSE: assert property (set_up |=> pready_o ##1 !pready_o)
    else $error("pready not one pulse after setup");
  AST_UNMAPPED_ERR: assert property (set_up && !mapped |=> pslverr_o && pready_o)
    else $error("no error on unmapped access");
  AST_MAPPED_OK: assert property (set_up && mapped |=> !pslverr_o)
    else $error("error on mapped access");
  AST_SPI_MASTER: assert property (spi_enable_bit_i && spi_master_select_i |=>
    port_e_pin_oe_o[7:6] == 2'h3 && !port_e_pin_oe_o[5]) else $error("master pins wrong");
  AST_SPI_SLAVE: assert property (spi_enable_bit_i && !spi_master_select_i |=>
    port_e_pin_oe_o[7:4] == 4'h2 && port_e_pin_o[5] == $past(spi_miso_out_i))
    else $error("slave pins wrong");
  AST_SELECT_OWNED: assert property (spi_enable_bit_i && spi_master_select_i &&
    mode_fault_enable_i |=> !port_e_pin_oe_o[4]) else $error("select pin driven");
  AST_SERIAL: assert property (serial_iface_enable_i |=> port_e_pin_oe_o[1:0] == 2'h1 &&
    port_e_pin_o[0] == $past(serial_txd_out_i)) else $error("serial pins wrong");
  AST_TIMER_E: assert property (edge_level_select_i[1:0] != 2'h0 |=>
    port_e_pin_oe_o[2] == $past(timer_ch_oe_i[0]) &&
    (!port_e_pin_oe_o[2] || port_e_pin_o[2] == $past(timer_ch_out_i[0])))
    else $error("timer pin wrong");
  AST_TIMER_F: assert property (edge_level_select_i[11:10] != 2'h0 |=>
    port_f_pin_oe_o[3] == $past(timer_ch_oe_i[5])) else $error("timer f pin wrong");
endmodule
bind gpef_ports gpef_ports_asserts u_asserts (.mclk_i, .reset_n_i, .psel_i, .penable_i,
  .paddr_i, .pready_o, .pslverr_o, .spi_enable_bit_i, .spi_master_select_i,
  .mode_fault_enable_i, .spi_miso_out_i, .serial_iface_enable_i, .serial_txd_out_i,
  .edge_level_select_i, .timer_ch_oe_i, .timer_ch_out_i, .port_e_pin_o,
  .port_e_pin_oe_o, .port_f_pin_oe_o);

/* File: test/gpef_ports_tb.sv */
`timescale 1ns/1ps
module gpef_ports_tb
  import gpef_pkg::*;
;
  logic mclk_i = 1'h0, reset_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h000, ext = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic [3:0] pstrb_i = 4'hF;
  logic pready_o, pslverr_o;
  gpef_periph_t per = gpef_periph_t'(32'h0);
  logic [7:0] e_out, e_oe, e_lvl, e_in;
  logic [3:0] f_out, f_oe, f_lvl, f_in;
  int miscompares = 0, num_checks = 0, cycles = 0;
  logic [32:0] expq[$];
  initial forever #20 mclk_i = ~mclk_i;
  gpef_ports DUT (.mclk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .spi_enable_bit_i(per.spi_enable_bit),
    .spi_master_select_i(per.spi_master_select), .mode_fault_enable_i(per.mode_fault_enable),
    .spi_sck_out_i(per.sck_out), .spi_mosi_out_i(per.mosi_out), .spi_miso_out_i(per.miso_out),
    .serial_iface_enable_i(per.serial_iface_enable), .serial_txd_out_i(per.txd_out),
    .edge_level_select_i(per.edge_level_select), .timer_ch_oe_i(per.tch_oe),
    .timer_ch_out_i(per.tch_out), .port_e_pin_i(e_lvl), .port_f_pin_i(f_lvl),
    .port_e_pin_o(e_out), .port_e_pin_oe_o(e_oe), .port_f_pin_o(f_out),
    .port_f_pin_oe_o(f_oe), .port_e_in_o(e_in), .port_f_in_o(f_in));
  gpef_pins_model u_pins (.e_out_i(e_out), .e_oe_i(e_oe), .f_out_i(f_out), .f_oe_i(f_oe),
    .ext_i(ext), .e_lvl_o(e_lvl), .f_lvl_o(f_lvl));
  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] x);
    @(posedge mclk_i);
    expq.push_back(x);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'h1;
    do @(posedge mclk_i); while (pready_o !== 1'h1);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  // ------------------------------------------------------------------
  // Response watcher and hang guard
  // ------------------------------------------------------------------
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (psel_i && penable_i && pready_o === 1'h1) begin
      chk({pslverr_o, pwrite_i ? 32'h0 : prdata_o}, expq.pop_front());
    end
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] le, de;
    logic [3:0] lf, df;
    logic [11:0] xo, xv, lv;
    gpef_periph_t p;
    int b;
    void'($urandom(32'h17EE6F31));
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    apb(1'h0, GPEF_ADDR_PORT_E_DIR, 32'h0, 33'h0);
    apb(1'h0, GPEF_ADDR_PORT_F_DIR, 32'h0, 33'h0);
    apb(1'h1, 12'h040, 32'hFF, {1'h1, 32'h0});
    apb(1'h0, 12'h040, 32'h0, {1'h1, 32'h0});
    for (int i = 0; i < 16; i++) begin
      le = 8'($urandom);
      lf = 4'($urandom);
      de = 8'($urandom);
      df = 4'($urandom);
      apb(1'h1, GPEF_ADDR_PORT_E_DATA, {24'h0, le}, 33'h0);
      apb(1'h1, GPEF_ADDR_PORT_F_DATA, {28'h0, lf}, 33'h0);
      apb(1'h1, GPEF_ADDR_PORT_E_DIR, {24'h0, de}, 33'h0);
      apb(1'h1, GPEF_ADDR_PORT_F_DIR, {28'h0, df}, 33'h0);
      p = gpef_periph_t'($urandom);
      {p.serial_iface_enable, p.mode_fault_enable, p.spi_master_select} = 3'(i >> 1);
      p.spi_enable_bit = i[0];
      p.edge_level_select &= (i < 4) ? 12'h000 : 12'($urandom);
      per <= p;
      ext <= 12'($urandom);
      repeat (6) @(posedge mclk_i);
      xo = {df, de};
      xv = {lf, le};
      if (p.spi_enable_bit) begin
        xo[7:4] = p.spi_master_select ? {3'h6, de[4] & ~p.mode_fault_enable} : 4'h2;
        xv[7:5] = {p.sck_out, p.mosi_out, p.miso_out};
      end
      if (p.serial_iface_enable) begin
        xo[1:0] = 2'h1;
        xv[0] = p.txd_out;
      end
      for (int c = 0; c < 6; c++) begin
        b = (c < 2) ? c + 2 : c + 6;
        if (p.edge_level_select[2*c +: 2] != 2'h0) begin
          xo[b] = p.tch_oe[c];
          xv[b] = p.tch_out[c];
        end
      end
      lv = (xo & xv) | (~xo & ext);
      chk({f_oe, e_oe, {f_out, e_out} & xo}, {xo, xv & xo});
      chk({f_in, e_in}, lv);
      apb(1'h0, GPEF_ADDR_PORT_E_DATA, 32'h0, {25'h0, (de & le) | (~de & lv[7:0])});
      apb(1'h0, GPEF_ADDR_PORT_F_DATA, 32'h0, {29'h0, (df & lf) | (~df & lv[11:8])});
    end
    pstrb_i <= 4'hE;
    apb(1'h1, GPEF_ADDR_PORT_E_DATA, {24'h0, ~le}, 33'h0);
    pstrb_i <= 4'hF;
    per <= gpef_periph_t'(32'h0);
    reset_n_i <= 1'h0;
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    chk({f_oe, e_oe}, 33'h0);
    apb(1'h1, GPEF_ADDR_PORT_E_DIR, 32'hFF, 33'h0);
    apb(1'h1, GPEF_ADDR_PORT_F_DIR, 32'hF, 33'h0);
    apb(1'h0, GPEF_ADDR_PORT_E_DATA, 32'h0, {25'h0, le});
    apb(1'h0, GPEF_ADDR_PORT_F_DATA, 32'h0, {29'h0, lf});
    repeat (2) @(posedge mclk_i);
    finish_test();
  end
endmodule
